// File: hdl/usc_core.sv
// usc_core: serial transceiver with hardware handshake, smart-card T=0/T=1
// and infrared modes, registers on an AHB-Lite slave.
// assumes one 25 MHz clock; pins cts_i, rxd_i, txd_i are asynchronous.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps

module usc_core
	import usc_pkg::*;
(
	input wire logic ref_clk_i, // 25 MHz clock
	input wire logic rstn_i, // synchronous reset, active low
	input wire usc_ahb_req_s ahb_i, // AHB-Lite request
	output usc_ahb_rsp_s ahb_o, // AHB-Lite response
	input wire logic receive_buffer_full_i, // dma receive buffer full
	input wire logic cts_i, // clear to send pin
	output logic rts_o, // request to send pin
	input wire logic rxd_i, // receive data pin
	input wire logic txd_i, // data pin input (smart-card line)
	output logic txd_o, // data pin output
	output logic txd_oe_o, // data pin output enable
	output logic sck_o, // card clock
	output logic ir_tx_o // infrared modulator pulse
);

	usc_state_s r;
	usc_state_s n;

	function automatic logic par_bit(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction

	function automatic logic [2:0] bit_idx(input logic [2:0] k,
		input logic bit_order_select);
		return bit_order_select ? 3'h7 - k : k;
	endfunction

	always_comb begin : next_state
		logic [3:0] md;
		logic hs, t0, t1, sc, ir;
		logic [2:0] par_f;
		logic par_en, odd, bit_order_select, two_stop;
		logic [2:0] max_iter;
		logic [15:0] div, div_m1, half;
		logic cts, rxin, io;
		logic aph;
		logic [7:0] ofs;
		logic [31:0] stat;
		logic [31:0] wd;
		logic fin, perr, tx_go, tx_drive;
		logic [17:0] prod;
		logic [15:0] pulse, elapsed;
		n = r;
		md = r.mode[USC_MR_MODE_LSB +: 4];
		hs = (md == USC_MODE_HS);
		t0 = (md == USC_MODE_T0);
		t1 = (md == USC_MODE_T1);
		sc = t0 | t1;
		ir = (md == USC_MODE_IR);
		par_f = r.mode[USC_MR_PAR_LSB +: 3];
		par_en = sc | ~par_f[2];
		odd = (par_f == USC_PAR_ODD);
		bit_order_select = r.mode[USC_MR_BIT_ORDER_SELECT];
		two_stop = r.mode[USC_MR_TWOSTOP] & ~t1;
		max_iter = r.mode[USC_MR_ITER_LSB +: 3];
		div = (r.brg[15:0] == 16'h0000) ? 16'h0001 : r.brg[15:0];
		div_m1 = div - 16'h0001;
		half = {1'b0, div[15:1]};
		cts = r.pin_f[2];
		io = r.pin_f[0];
		rxin = sc ? r.pin_f[0] : r.pin_f[1];
		aph = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
		ofs = ahb_i.haddr[7:0];
		wd = ahb_i.hwdata;
		fin = 1'b0;
		perr = 1'b0;
		tx_go = 1'b0;

		// pin synchronisers: a change counts once stages two and three agree
		for (int i = 0; i < 3; i++) begin
			n.sync1[i] = (i == 2) ? cts_i : ((i == 1) ? rxd_i : txd_i);
			n.sync2[i] = r.sync1[i];
			n.sync3[i] = r.sync2[i];
			if (r.sync2[i] == r.sync3[i]) begin
				n.pin_f[i] = r.sync3[i];
			end
		end

		// status word
		stat = 32'h0000_0000;
		stat[USC_SR_RECEIVE_READY_FLAG] = r.receive_ready_flag;
		stat[USC_SR_TXRDY] = ~r.thr_valid;
		stat[USC_SR_PARITY_ERROR_FLAG] = r.parity_error_flag;
		stat[USC_SR_TXEMPTY] = ~r.thr_valid & (r.tx_st == TX_IDLE);
		stat[USC_SR_ITER] = r.iter_f;
		stat[USC_SR_NACK] = r.inhibit_nack_bit_f;
		stat[USC_SR_CTS] = cts;
		stat[USC_SR_RXEN] = r.rx_en;
		stat[USC_SR_TXEN] = r.tx_en;

		// bus address phase: read data and read side effects
		n.dph_wr = aph & ahb_i.hwrite;
		n.dph_addr = ofs;
		n.rdata = 32'h0000_0000;
		if (aph && !ahb_i.hwrite) begin
			case (ofs)
				USC_MODE_OFS: n.rdata = r.mode;
				USC_STAT_OFS: n.rdata = stat;
				USC_RHR_OFS: begin
					n.rdata = {24'h00_0000, r.rhr};
					n.receive_ready_flag = 1'b0;
				end
				USC_BRG_OFS: n.rdata = {8'h00, r.brg[23:0]};
				USC_NER_OFS: begin
					n.rdata = {24'h00_0000, r.nerr};
					n.nerr = 8'h00;
				end
				default: n.rdata = 32'h0000_0000;
			endcase
		end

		// bus data phase: writes and commands
		if (r.dph_wr) begin
			case (r.dph_addr)
				USC_CTRL_OFS: begin
					if (wd[USC_CR_RXEN]) n.rx_en = 1'b1;
					if (wd[USC_CR_RXDIS]) n.rx_en = 1'b0;
					if (wd[USC_CR_TXEN]) n.tx_en = 1'b1;
					if (wd[USC_CR_TXDIS]) n.tx_en = 1'b0;
					if (wd[USC_CR_RSTSTA]) n.parity_error_flag = 1'b0;
					if (wd[USC_CR_RSTIT]) n.iter_f = 1'b0;
					if (wd[USC_CR_RESET_NACK_CMD]) n.inhibit_nack_bit_f = 1'b0;
				end
				USC_MODE_OFS: n.mode = wd;
				USC_BRG_OFS: n.brg = {8'h00, wd[23:0]};
				default: n.mode = n.mode;
			endcase
		end

		// transmitter
		case (r.tx_st)
			TX_IDLE: begin
				n.tx_line = 1'b1;
				if (r.tx_en && r.thr_valid && !(hs && cts)) begin
					n.tx_byte = r.thr;
					n.thr_valid = 1'b0;
					n.tx_iter = 3'h0;
					tx_go = 1'b1;
				end
			end
			TX_START, TX_DATA, TX_PAR, TX_STOP: begin
				if (r.tx_cnt != 16'h0000) begin
					n.tx_cnt = r.tx_cnt - 16'h0001;
				end else begin
					n.tx_cnt = div_m1;
					case (r.tx_st)
						TX_START: begin
							n.tx_st = TX_DATA;
							n.tx_bit = 3'h0;
							n.tx_line = r.tx_byte[bit_idx(3'h0, bit_order_select)];
						end
						TX_DATA: begin
							if (r.tx_bit != 3'h7) begin
								n.tx_bit = r.tx_bit + 3'h1;
								n.tx_line =
									r.tx_byte[bit_idx(n.tx_bit, bit_order_select)];
							end else if (par_en) begin
								n.tx_st = TX_PAR;
								n.tx_line = par_bit(r.tx_byte, odd);
							end else begin
								n.tx_st = TX_STOP;
								n.tx_line = 1'b1;
								n.tx_gb = {1'b0, two_stop};
							end
						end
						TX_PAR: begin
							n.tx_line = 1'b1;
							n.tx_gb = {1'b0, t0 | two_stop};
							n.tx_nack = 1'b0;
							n.tx_st = t0 ? TX_GUARD : TX_STOP;
						end
						default: begin
							if (r.tx_gb == 2'h0) begin
								n.tx_st = TX_IDLE;
							end else begin
								n.tx_gb = r.tx_gb - 2'h1;
							end
						end
					endcase
				end
			end
			TX_GUARD: begin
				if (r.tx_cnt != 16'h0000) begin
					n.tx_cnt = r.tx_cnt - 16'h0001;
					if (r.tx_cnt == half && r.tx_gb == 2'h1 &&
						!r.tx_nack && !io) begin
						n.tx_nack = 1'b1;
						n.tx_gb = 2'h2;
					end
				end else if (r.tx_gb != 2'h0) begin
					n.tx_cnt = div_m1;
					n.tx_gb = r.tx_gb - 2'h1;
				end else if (r.tx_nack && max_iter != 3'h0 &&
					r.tx_iter != max_iter) begin
					n.tx_iter = r.tx_iter + 3'h1;
					if (n.tx_iter == max_iter) begin
						n.iter_f = 1'b1;
					end
					tx_go = 1'b1;
				end else begin
					n.tx_iter = 3'h0;
					n.tx_st = TX_IDLE;
				end
			end
			default: n.tx_st = TX_IDLE;
		endcase
		if (tx_go) begin
			n.tx_st = TX_START;
			n.tx_line = 1'b0;
			n.tx_cnt = div_m1;
			n.tx_nack = 1'b0;
		end

		// holding register write after the transmitter took the old byte
		if (r.dph_wr && r.dph_addr == USC_THR_OFS) begin
			n.thr = wd[7:0];
			n.thr_valid = 1'b1;
		end

		// receiver
		if (r.rx_st != RX_IDLE && r.rx_cnt != 16'h0000) begin
			n.rx_cnt = r.rx_cnt - 16'h0001;
		end else begin
			case (r.rx_st)
				RX_IDLE: begin
					if (r.rx_en && !rxin) begin
						n.rx_st = RX_START;
						n.rx_cnt = half;
					end
				end
				RX_START: begin
					n.rx_st = rxin ? RX_IDLE : RX_DATA;
					n.rx_cnt = div_m1;
					n.rx_bit = 3'h0;
				end
				RX_DATA: begin
					n.rx_byte[bit_idx(r.rx_bit, bit_order_select)] = rxin;
					n.rx_cnt = div_m1;
					if (r.rx_bit != 3'h7) begin
						n.rx_bit = r.rx_bit + 3'h1;
					end else if (par_en) begin
						n.rx_st = RX_PAR;
					end else begin
						fin = 1'b1;
					end
				end
				RX_PAR: begin
					fin = 1'b1;
					perr = (rxin != par_bit(r.rx_byte, odd));
				end
				RX_STOP: begin
					if (r.rx_nack) begin
						n.rx_st = RX_NACK;
						n.rx_oe = 1'b1;
						n.rx_nack = 1'b0;
						n.rx_cnt = div_m1;
					end else begin
						n.rx_st = RX_IDLE;
					end
				end
				RX_NACK: begin
					n.rx_oe = 1'b0;
					n.rx_st = RX_IDLE;
				end
				default: n.rx_st = RX_IDLE;
			endcase
		end

		// end of character: store, flag, count and nack decisions
		if (fin) begin
			n.rx_st = RX_STOP;
			n.rx_cnt = t0 ? half : div_m1;
			if (!perr) begin
				n.rhr = n.rx_byte;
				n.receive_ready_flag = 1'b1;
				n.nack_cnt = 3'h0;
			end else begin
				if (n.nerr != 8'hFF) begin
					n.nerr = n.nerr + 8'h01;
				end
				if (!t0) begin
					n.parity_error_flag = 1'b1;
					n.rhr = n.rx_byte;
					n.receive_ready_flag = 1'b1;
				end else if (r.mode[USC_MR_INHIBIT_NACK_BIT]) begin
					n.inhibit_nack_bit_f = 1'b1;
					n.rhr = n.rx_byte;
				end else if (r.mode[USC_MR_NACK_LIMIT_ENABLE] &&
					r.nack_cnt == max_iter) begin
					n.rhr = n.rx_byte;
					n.receive_ready_flag = 1'b1;
					n.iter_f = 1'b1;
					n.nack_cnt = 3'h0;
				end else begin
					n.parity_error_flag = 1'b1;
					n.rx_nack = 1'b1;
					if (r.nack_cnt != 3'h7) begin
						n.nack_cnt = r.nack_cnt + 3'h1;
					end
				end
			end
		end

		// card clock from the divider
		if (sc) begin
			if (r.sck_cnt == 8'h00) begin
				n.sck = ~r.sck;
				n.sck_cnt = r.brg[23:16];
			end else begin
				n.sck_cnt = r.sck_cnt - 8'h01;
			end
		end else begin
			n.sck = 1'b0;
			n.sck_cnt = 8'h00;
		end

		// pin drivers
		tx_drive = (n.tx_st != TX_IDLE) && (n.tx_st != TX_GUARD);
		n.txd = (sc && n.rx_oe) ? 1'b0 : n.tx_line;
		n.txd_oe = sc ? (tx_drive | n.rx_oe) : 1'b1;
		n.rts = hs & ~r.rx_en & receive_buffer_full_i;

		// infrared modulator: pulse for 3/16 of each zero bit
		prod = {2'b00, div} * 18'h00003;
		pulse = {2'b00, prod[17:4]};
		elapsed = div_m1 - n.tx_cnt;
		n.ir_tx = ir && (n.tx_st != TX_IDLE) && !n.tx_line &&
			(elapsed < pulse);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			r <= USC_STATE_RST;
		end else begin
			r <= n;
		end
	end

	assign ahb_o.hrdata = r.rdata;
	assign ahb_o.hreadyout = 1'b1;
	assign ahb_o.hresp = 1'b0;
	assign rts_o = r.rts;
	assign txd_o = r.txd;
	assign txd_oe_o = r.txd_oe;
	assign sck_o = r.sck;
	assign ir_tx_o = r.ir_tx;

endmodule // usc_core

// File: hdl/usc_pkg.sv
// usc_pkg: register map, field layout, reset values, states and carriers
// of the serial transceiver with handshake, smart-card and infrared modes.
// assumes a 32-bit AHB-Lite slave port with word-aligned registers.
package usc_pkg;

	// register byte offsets
	localparam logic [7:0] USC_CTRL_OFS = 8'h00;
	localparam logic [7:0] USC_MODE_OFS = 8'h04;
	localparam logic [7:0] USC_STAT_OFS = 8'h14;
	localparam logic [7:0] USC_RHR_OFS = 8'h18;
	localparam logic [7:0] USC_THR_OFS = 8'h1C;
	localparam logic [7:0] USC_BRG_OFS = 8'h20;
	localparam logic [7:0] USC_NER_OFS = 8'h44;

	// operating mode codes
	localparam logic [3:0] USC_MODE_NORMAL = 4'h0;
	localparam logic [3:0] USC_MODE_HS = 4'h2;
	localparam logic [3:0] USC_MODE_T0 = 4'h4;
	localparam logic [3:0] USC_MODE_T1 = 4'h5;
	localparam logic [3:0] USC_MODE_IR = 4'h8;

	// mode register fields
	localparam int USC_MR_MODE_LSB = 0;
	localparam int USC_MR_PAR_LSB = 9;
	localparam int USC_MR_TWOSTOP = 12;
	localparam int USC_MR_BIT_ORDER_SELECT = 16;
	localparam int USC_MR_INHIBIT_NACK_BIT = 20;
	localparam int USC_MR_NACK_LIMIT_ENABLE = 21;
	localparam int USC_MR_ITER_LSB = 24;
	localparam logic [2:0] USC_PAR_ODD = 3'h1;

	// control register command bits
	localparam int USC_CR_RXEN = 4;
	localparam int USC_CR_RXDIS = 5;
	localparam int USC_CR_TXEN = 6;
	localparam int USC_CR_TXDIS = 7;
	localparam int USC_CR_RSTSTA = 8;
	localparam int USC_CR_RSTIT = 13;
	localparam int USC_CR_RESET_NACK_CMD = 14;

	// status register bits
	localparam int USC_SR_RECEIVE_READY_FLAG = 0;
	localparam int USC_SR_TXRDY = 1;
	localparam int USC_SR_PARITY_ERROR_FLAG = 7;
	localparam int USC_SR_TXEMPTY = 9;
	localparam int USC_SR_ITER = 10;
	localparam int USC_SR_NACK = 13;
	localparam int USC_SR_CTS = 19;
	localparam int USC_SR_RXEN = 20;
	localparam int USC_SR_TXEN = 21;

	// reset values: bit period 16 clocks, card clock half period 5 clocks
	localparam logic [31:0] USC_MODE_RST = 32'h0000_0000;
	localparam logic [31:0] USC_BRG_RST = 32'h0004_0010;
	localparam logic [2:0] USC_PIN_RST = 3'h7;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b011,
		TX_PAR = 3'b010,
		TX_STOP = 3'b110,
		TX_GUARD = 3'b111
	} usc_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b011,
		RX_PAR = 3'b010,
		RX_STOP = 3'b110,
		RX_NACK = 3'b111
	} usc_rx_e;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} usc_ahb_req_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} usc_ahb_rsp_s;

	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] brg;
		logic rx_en;
		logic tx_en;
		logic [7:0] thr;
		logic thr_valid;
		logic [7:0] rhr;
		logic receive_ready_flag;
		logic parity_error_flag;
		logic inhibit_nack_bit_f;
		logic iter_f;
		logic [7:0] nerr;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] sync3;
		logic [2:0] pin_f;
		usc_tx_e tx_st;
		logic [15:0] tx_cnt;
		logic [7:0] tx_byte;
		logic [2:0] tx_bit;
		logic [1:0] tx_gb;
		logic tx_line;
		logic tx_nack;
		logic [2:0] tx_iter;
		usc_rx_e rx_st;
		logic [15:0] rx_cnt;
		logic [7:0] rx_byte;
		logic [2:0] rx_bit;
		logic rx_nack;
		logic rx_oe;
		logic [2:0] nack_cnt;
		logic dph_wr;
		logic [7:0] dph_addr;
		logic [31:0] rdata;
		logic [7:0] sck_cnt;
		logic sck;
		logic txd;
		logic txd_oe;
		logic rts;
		logic ir_tx;
	} usc_state_s;

	localparam usc_state_s USC_STATE_RST = '{
		mode: USC_MODE_RST,
		brg: USC_BRG_RST,
		sync1: USC_PIN_RST,
		sync2: USC_PIN_RST,
		sync3: USC_PIN_RST,
		pin_f: USC_PIN_RST,
		tx_st: TX_IDLE,
		rx_st: RX_IDLE,
		tx_line: 1'b1,
		txd: 1'b1,
		txd_oe: 1'b1,
		default: '0
	};

endpackage

// File: tb/usc_sva.sv
// usc_sva: port checks of the serial transceiver.
// assumes the reset values and rules of usc_core.
`timescale 1ns/100ps

module usc_sva
	import usc_pkg::*;
(
	input wire logic ref_clk_i, // clock
	input wire logic rstn_i, // reset, low
	input wire usc_ahb_req_s ahb_i, // bus in
	input wire usc_ahb_rsp_s ahb_o, // bus out
	input wire logic receive_buffer_full_i, // buffer full
	input wire logic rts_o, // rts
	input wire logic txd_o, // data out
	input wire logic txd_oe_o, // data enable
	input wire logic sck_o, // card clock
	input wire logic ir_tx_o // ir pulse
);
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// cycles that the data line has been released; a release on entry to
	// smart-card mode (card clock idle) counts as long ago.
	// assumes a card clock half period below 15 clocks
	logic [7:0] low_n;
	logic [3:0] sck_age;
	logic sck_q;
	always_ff @(posedge ref_clk_i) begin
		sck_q <= sck_o;
		if (!rstn_i)
			sck_age <= 4'hF;
		else if (sck_o != sck_q)
			sck_age <= 4'h0;
		else if (sck_age != 4'hF)
			sck_age <= sck_age + 4'h1;
		if (!rstn_i || txd_oe_o)
			low_n <= (sck_age == 4'hF) ? 8'hFF : 8'h00;
		else if (low_n != 8'hFF)
			low_n <= low_n + 8'h01;
	end

	bus_okay_a: assert property (ahb_o.hreadyout && !ahb_o.hresp)
		else $error("bus answer bad");
	rd_idle_a: assert property (!$past(ahb_i.hsel && ahb_i.htrans[1]
		&& !ahb_i.hwrite) |-> ahb_o.hrdata == 32'h0)
		else $error("read data outside data phase");
	rst_pins_a: assert property ($rose(rstn_i) |-> !rts_o && txd_o
		&& txd_oe_o && !sck_o && !ir_tx_o)
		else $error("pins wrong after reset");
	rts_src_a: assert property (rts_o |-> $past(receive_buffer_full_i))
		else $error("rts without buffer full");
	rts_drop_a: assert property ($fell(receive_buffer_full_i) |=> !rts_o)
		else $error("rts stays high");
	rts_mode_a: assert property (rts_o |-> !sck_o && txd_oe_o)
		else $error("rts outside handshake");
	ir_mode_a: assert property (ir_tx_o |-> txd_oe_o && !sck_o)
		else $error("ir pulse outside ir mode");
	guard_len_a: assert property ($rose(txd_oe_o) && $past(rstn_i)
		|-> low_n >= 8'd32)
		else $error("guard time short");
endmodule // usc_sva

bind usc_core usc_sva chk (
	.ref_clk_i,
	.rstn_i,
	.ahb_i,
	.ahb_o,
	.receive_buffer_full_i,
	.rts_o,
	.txd_o,
	.txd_oe_o,
	.sck_o,
	.ir_tx_o
);

// File: tb/usc_card.sv
// usc_card: behavioural smart card on the shared data line.
// assumes 16 clocks a bit and a pull-up on the line.
`timescale 1ns/100ps

module usc_card (
	input wire logic clk_i, // clock
	input wire logic line_i, // resolved line
	input wire logic rts_i, // rts of block
	output logic low_o // pulls line low
);
	int nacks = 0; // nacks still to give
	int got = 0; // characters seen
	logic [7:0] last = 8'h00;
	logic saw_nack = 1'b0;
	logic busy = 1'b0;
	logic [8:0] sh;

	initial low_o = 1'b0;

	always begin
		@(posedge clk_i iff (line_i === 1'b0 && !busy));
		repeat (8) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (16) @(posedge clk_i);
			sh[i] = line_i;
		end
		got++;
		last = sh[7:0];
		repeat (8) @(posedge clk_i);
		if (nacks > 0 || ^sh) begin
			nacks = nacks - (nacks > 0);
			low_o <= 1'b1;
			repeat (16) @(posedge clk_i);
			low_o <= 1'b0;
		end
		repeat (16) @(posedge clk_i);
	end

	task automatic send(input logic [7:0] b, input logic bad);
		logic [9:0] f;
		f = {^b ^ bad, b, 1'b0};
		busy = 1'b1;
		@(posedge clk_i iff !rts_i);
		for (int i = 0; i < 10; i++) begin
			low_o <= !f[i];
			repeat (16) @(posedge clk_i);
		end
		low_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		saw_nack = !line_i;
		repeat (32) @(posedge clk_i);
		busy = 1'b0;
	endtask
endmodule // usc_card

// File: tb/usc_core_tb.sv
// usc_core_tb: bus and line tests of the serial transceiver.
// assumes usc_core, usc_card and the bound checker.
`timescale 1ns/100ps

module usc_core_tb
	import usc_pkg::*;
();
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic receive_buffer_full = 1'b0;
	logic cts = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	usc_ahb_req_s rq;
	usc_ahb_rsp_s rsp;
	logic rts, txd, oe, sck, ir, low, line;
	logic [31:0] r;
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	int nk[3] = '{1, 5, 9};
	int lim[3] = '{3, 2, 7};

	always #20 clk = ~clk;
	assign rq = '{hsel: 1'b1, haddr: haddr, htrans: htrans,
		hwrite: hwrite, hsize: 3'h2, hwdata: hwdata,
		hready: rsp.hreadyout};
	assign line = !((oe && !txd) || low);

	usc_core dut (
		.ref_clk_i(clk),
		.rstn_i(rstn),
		.ahb_i(rq),
		.ahb_o(rsp),
		.receive_buffer_full_i(receive_buffer_full),
		.cts_i(cts),
		.rts_o(rts),
		.rxd_i(1'b1),
		.txd_i(line),
		.txd_o(txd),
		.txd_oe_o(oe),
		.sck_o(sck),
		.ir_tx_o(ir)
	);
	usc_card card (
		.clk_i(clk),
		.line_i(line),
		.rts_i(rts),
		.low_o(low)
	);

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		r = rsp.hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask

	task automatic hs(input logic b, input logic e);
		@(posedge clk);
		receive_buffer_full <= b;
		repeat (4) @(posedge clk);
		chk(rts, e);
	endtask

	task automatic count(input int c, ref logic s);
		n = 0;
		repeat (c) begin
			@(posedge clk);
			n += (s === 1'b1);
		end
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(USC_MODE_OFS, '1, USC_MODE_RST);
		rd(USC_BRG_OFS, '1, USC_BRG_RST);
		wr(8'h80, '1);
		rd(8'h80, '1, 32'h0);
		// handshake: rts follows receiver state and buffer full
		wr(USC_MODE_OFS, {28'h0, USC_MODE_HS});
		wr(USC_CTRL_OFS, 32'h20);
		hs(1'b1, 1'b1);
		hs(1'b0, 1'b0);
		hs(1'b1, 1'b1);
		wr(USC_CTRL_OFS, 32'h10);
		hs(1'b1, 1'b0);
		wr(USC_MODE_OFS, 32'h0);
		wr(USC_CTRL_OFS, 32'h20);
		hs(1'b1, 1'b0);
		// cts high holds the character
		wr(USC_MODE_OFS, {28'h0, USC_MODE_HS});
		cts <= 1'b1;
		wr(USC_CTRL_OFS, 32'h60);
		wr(USC_THR_OFS, 32'hA5);
		count(80, txd);
		chk(n, 80);
		chk(txd, 1'b1);
		cts <= 1'b0;
		n = 0;
		while (txd !== 1'b0 && n < 30) begin
			@(posedge clk);
			n++;
		end
		chk(n < 30, 1'b1);
		repeat (250) @(posedge clk);
		// T=0 transmit with card nacks against repeat limits
		for (int k = 0; k < 3; k++) begin
			card.nacks = nk[k];
			n = card.got;
			wr(USC_MODE_OFS, 32'h4 | (lim[k] << 24));
			wr(USC_CTRL_OFS, 32'h2060);
			wr(USC_THR_OFS, 32'h3C);
			repeat (260 * (lim[k] + 1)) @(posedge clk);
			chk(card.got - n, (nk[k] < lim[k] ? nk[k] : lim[k]) + 1);
			chk(card.last, 32'h3C);
			rd(USC_STAT_OFS, 32'h400, (nk[k] >= lim[k]) << 10);
		end
		card.nacks = 0;
		wr(USC_CTRL_OFS, 32'h2000);
		rd(USC_STAT_OFS, 32'h400, 32'h0);
		count(40, sck);
		chk(n > 0 && oe === 1'b0, 1'b1);
		// T=0 receive: nack, error count, inhibit, nack limit
		wr(USC_MODE_OFS, 32'h4);
		wr(USC_CTRL_OFS, 32'h90);
		card.send(8'h5A, 1'b1);
		chk(card.saw_nack, 1'b1);
		rd(USC_STAT_OFS, 32'h81, 32'h80);
		rd(USC_NER_OFS, 32'hFF, 32'h1);
		rd(USC_NER_OFS, 32'hFF, 32'h0);
		wr(USC_CTRL_OFS, 32'h100);
		card.send(8'h66, 1'b0);
		chk(card.saw_nack, 1'b0);
		rd(USC_RHR_OFS, 32'hFF, 32'h66);
		wr(USC_MODE_OFS, 32'h0001_0204);
		card.send(8'h0F, 1'b1);
		chk(card.saw_nack, 1'b0);
		rd(USC_RHR_OFS, 32'hFF, 32'hF0);
		wr(USC_MODE_OFS, 32'h0010_0004);
		card.send(8'hC3, 1'b1);
		chk(card.saw_nack, 1'b0);
		rd(USC_STAT_OFS, 32'h2001, 32'h2000);
		rd(USC_RHR_OFS, 32'hFF, 32'hC3);
		wr(USC_CTRL_OFS, 32'h4000);
		rd(USC_STAT_OFS, 32'h2000, 32'h0);
		wr(USC_MODE_OFS, 32'h0120_0004);
		card.send(8'h81, 1'b1);
		chk(card.saw_nack, 1'b1);
		card.send(8'h81, 1'b1);
		chk(card.saw_nack, 1'b0);
		rd(USC_STAT_OFS, 32'h400, 32'h400);
		// T=1 parity check, infrared pulses
		wr(USC_MODE_OFS, {28'h0, USC_MODE_T1});
		wr(USC_CTRL_OFS, 32'h100);
		card.send(8'h11, 1'b1);
		rd(USC_STAT_OFS, 32'h80, 32'h80);
		wr(USC_MODE_OFS, {28'h0, USC_MODE_IR});
		wr(USC_CTRL_OFS, 32'h60);
		wr(USC_THR_OFS, 32'h0);
		count(250, ir);
		chk(n > 0, 1'b1);
		give_verdict();
	end
endmodule // usc_core_tb
